/* hdl/elci_consts.svh */
// Constants for the encoder line-count and initialisation block.
// Assumes inclusion by bare name from files that need offsets or counts.
`ifndef ELCI_CONSTS_SVH
`define ELCI_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ELCI_OFF_CTRL 8'h00
`define ELCI_OFF_ENC_CFG 8'h04
`define ELCI_OFF_LINES 8'h08
`define ELCI_OFF_POLES1 8'h0c
`define ELCI_OFF_POLES2 8'h10
`define ELCI_OFF_REINIT 8'h14
`define ELCI_OFF_STATUS 8'h18
`define ELCI_OFF_EFFECTIVE 8'h1c
`define ELCI_OFF_IRQ_STAT 8'h20
`define ELCI_OFF_IRQ_MASK 8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ELCI_CTRL_GEN_NEW 0
`define ELCI_CTRL_AUTOCFG 1
`define ELCI_CTRL_DRV_EN 2
`define ELCI_CFG_LINEAR 4
`define ELCI_ST_DONE 0
`define ELCI_ST_COMMUT 1
`define ELCI_ST_BUSY 2
`define ELCI_IRQ_DONE 0
`define ELCI_IRQ_START 1
`define ELCI_IRQ_REFUSED 2

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define ELCI_CTRL_RST 3'h1
`define ELCI_LINES_RST 16'h0400
`define ELCI_POLES_RST 8'h04
`define ELCI_LINES_MAX 16'hc350
`define ELCI_MIN_NEW 16'h0001
`define ELCI_MIN_OLD 16'h0002
`define ELCI_PLAIN_LIM_OLD 16'h4000
`define ELCI_CAP_COMM_OLD 16'h4000
`define ELCI_CAP_SC 16'h8000
`define ELCI_ANG_120 16'h5555

// ----------------------------------------
// Trip codes whose reset restarts initialisation
// ----------------------------------------
`define ELCI_TRIP_A_LO 5'h01
`define ELCI_TRIP_A_HI 5'h08
`define ELCI_TRIP_B_LO 5'h0b
`define ELCI_TRIP_B_HI 5'h11
`define ELCI_TRIP_SUPPLY 5'h1f

// ----------------------------------------
// Timing
// ----------------------------------------
`define ELCI_CLK_MHZ 50
`define ELCI_SETTLE_NS 1000
`define ELCI_SETTLE_CYC ((`ELCI_SETTLE_NS * `ELCI_CLK_MHZ + 999) / 1000)

`endif

/* hdl/elci_line_map.sv */
// Mapper from the stored line setting to the effective line count.
// Assumes a settled setting; result is combinational.
`include "elci_consts.svh"
`timescale 1ns/1ns
module elci_line_map (
   elci_map_if.map m
);

   function automatic logic [15:0] pow2_floor(input logic [15:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            r = 16'(16'h0001 << i);
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] pow2_clamp(input logic [15:0] v, input logic [15:0] lo,
      input logic [15:0] hi);
      if (v <= lo) begin
         return lo;
      end else if (v >= hi) begin
         return hi;
      end
      return pow2_floor(v);
   endfunction

   always_comb begin
      m.effective = m.setting;
      if (m.gen_new) begin
         // Rotary serial types only; linear keeps the setting
         if (m.enc_type >= elci_pkg::sine_cosine_serial_type_a && !m.linear) begin
            m.effective = pow2_clamp(m.setting, `ELCI_MIN_NEW, `ELCI_CAP_SC);
         end
      end else begin
         if (m.enc_type <= elci_pkg::fwd_rev_incremental) begin
            if (m.setting < `ELCI_MIN_OLD) begin
               m.effective = `ELCI_MIN_OLD;
            end else if (m.setting > `ELCI_PLAIN_LIM_OLD) begin
               m.effective = {m.setting[15:2], 2'b00};
            end
         end else if (m.enc_type <= elci_pkg::fwd_rev_with_commutation) begin
            m.effective = pow2_clamp(m.setting, `ELCI_MIN_OLD, `ELCI_CAP_COMM_OLD);
         end else begin
            m.effective = pow2_clamp(m.setting, `ELCI_MIN_OLD, `ELCI_CAP_SC);
         end
      end
   end

endmodule

/* hdl/elci_map_if.sv */
// Carrier between the control top and the line-count mapper.
// Assumes the mapper is purely combinational.
`timescale 1ns/1ns
interface elci_map_if;
   logic [15:0] setting;
   elci_pkg::elci_enc_t enc_type;
   logic linear;
   logic gen_new;
   logic [15:0] effective;

   modport req (output setting, output enc_type, output linear, output gen_new,
      input effective);
   modport map (input setting, input enc_type, input linear, input gen_new,
      output effective);
endinterface

/* hdl/elci_pkg.sv */
// Types shared by the encoder line-count and initialisation block.
// Assumes nothing beyond a SystemVerilog compiler.
package elci_pkg;

   typedef enum logic [3:0] {
      quadrature_incremental,
      freq_dir_incremental,
      fwd_rev_incremental,
      quadrature_with_commutation,
      freq_dir_with_commutation,
      fwd_rev_with_commutation,
      sine_cosine_plain,
      sine_cosine_serial_type_a,
      sine_cosine_serial_type_b,
      sine_cosine_synchronous_serial
   } elci_enc_t;

   typedef enum logic [1:0] {
      st_powerup,
      st_start,
      st_wait,
      st_idle
   } elci_state_t;

endpackage

/* hdl/elci_top.sv */
// Encoder line-count restriction and encoder initialisation sequencer.
// Assumes encoder ready lines come from pins; trip and angle inputs share core_clk.
`include "elci_consts.svh"
`timescale 1ns/1ns

// Operation
// - Line setting accepts zero up to 50,000; larger writes saturate.
// - Newer: incremental, commutation and plain sine-cosine use setting unchanged.
// - Newer rotary serial: 1 at or below 1, power of two, cap 32,768.
// - Newer linear serial encoders use setting unchanged.
// - Older plain incremental: 2 below 2, unchanged to 16,384, else multiple of 4.
// - Older commutation types: 2 at or below 2, power of two, cap 16,384.
// - Older sine-cosine types: 2 at or below 2, power of two, cap 32,768.
// - Done flag cleared at power-up, set once all encoders are ready.
// - Drive output enable is refused while done flag is clear.
// - Initialisation starts at power-up and on a re-initialise write.
// - Initialisation starts when supply or encoder fault trips are reset.
// - Newer generation only: initialisation starts when line setting or a pole count changes.
// - Start re-initialises serial encoders and, for serial types only, runs auto-configuration if selected.
// - Commutation types use commutation signals for first 120 degrees after restart.
module elci_top #(
   parameter int N_OPT = 2
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic enc_main_ready,
   input wire logic [N_OPT-1:0] opt_enc_ready,
   input wire logic trip_reset,
   input wire logic [4:0] trip_code,
   input wire logic motor_restart,
   input wire logic [15:0] elec_angle,
   output logic enc_serial_reinit,
   output logic enc_autocfg_run,
   output logic drive_enable,
   output logic commutation_active,
   output logic irq
);

   localparam logic [7:0] SETTLE_CYC = 8'(`ELCI_SETTLE_CYC);

   if (N_OPT < 1 || N_OPT > 8) begin : g_bad_nopt
      $error("N_OPT must be 1 to 8");
   end

   function automatic logic restart_trip(input logic [4:0] code);
      return (code == `ELCI_TRIP_SUPPLY)
         || (code >= `ELCI_TRIP_A_LO && code <= `ELCI_TRIP_A_HI)
         || (code >= `ELCI_TRIP_B_LO && code <= `ELCI_TRIP_B_HI);
   endfunction

   // ----------------------------------------
   // Ready synchronisers
   // ----------------------------------------
   logic [N_OPT:0] rdy_meta_reg;
   logic [N_OPT:0] rdy_sync_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdy_meta_reg <= '0;
         rdy_sync_reg <= '0;
      end else begin
         rdy_meta_reg <= {opt_enc_ready, enc_main_ready};
         rdy_sync_reg <= rdy_meta_reg;
      end
   end

   wire logic all_ready = &rdy_sync_reg;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [2:0] ctrl_reg, ctrl_next;
   elci_pkg::elci_enc_t type_reg, type_next;
   logic linear_reg, linear_next;
   logic [15:0] lines_reg, lines_next;
   logic [7:0] poles1_reg, poles1_next;
   logic [7:0] poles2_reg, poles2_next;
   logic [2:0] irq_stat_reg, irq_stat_next;
   logic [2:0] irq_mask_reg, irq_mask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [15:0] eff_reg, eff_next;
   logic cfg_change, reinit_wr;
   logic [2:0] irq_event;

   elci_map_if mif ();
   elci_line_map u_map (
      .m (mif.map)
   );

   assign mif.setting = lines_reg;
   assign mif.enc_type = type_reg;
   assign mif.linear = linear_reg;
   assign mif.gen_new = ctrl_reg[`ELCI_CTRL_GEN_NEW];

   logic done_reg, done_next;
   logic comm_reg, comm_next;
   elci_pkg::elci_state_t state_reg, state_next;

   always_comb begin
      ctrl_next = ctrl_reg;
      type_next = type_reg;
      linear_next = linear_reg;
      lines_next = lines_reg;
      poles1_next = poles1_reg;
      poles2_next = poles2_reg;
      irq_mask_next = irq_mask_reg;
      rdata_next = 32'h0000_0000;
      cfg_change = 1'b0;
      reinit_wr = 1'b0;
      eff_next = mif.effective;
      if (reg_wr) begin
         if (reg_addr == `ELCI_OFF_CTRL) begin
            ctrl_next = reg_wdata[2:0];
         end else if (reg_addr == `ELCI_OFF_ENC_CFG) begin
            if (reg_wdata[3:0] <= 4'(elci_pkg::sine_cosine_synchronous_serial)) begin
               type_next = elci_pkg::elci_enc_t'(reg_wdata[3:0]);
            end
            linear_next = reg_wdata[`ELCI_CFG_LINEAR];
         end else if (reg_addr == `ELCI_OFF_LINES) begin
            // Store saturates rather than wraps so software never sees an alias
            lines_next = (reg_wdata > 32'(`ELCI_LINES_MAX)) ? `ELCI_LINES_MAX
               : reg_wdata[15:0];
            cfg_change = (lines_next != lines_reg);
         end else if (reg_addr == `ELCI_OFF_POLES1) begin
            poles1_next = reg_wdata[7:0];
            cfg_change = (reg_wdata[7:0] != poles1_reg);
         end else if (reg_addr == `ELCI_OFF_POLES2) begin
            poles2_next = reg_wdata[7:0];
            cfg_change = (reg_wdata[7:0] != poles2_reg);
         end else if (reg_addr == `ELCI_OFF_REINIT) begin
            reinit_wr = 1'b1;
         end else if (reg_addr == `ELCI_OFF_IRQ_MASK) begin
            irq_mask_next = reg_wdata[2:0];
         end
      end
      if (reg_rd) begin
         if (reg_addr == `ELCI_OFF_CTRL) begin
            rdata_next = {29'h0, ctrl_reg};
         end else if (reg_addr == `ELCI_OFF_ENC_CFG) begin
            rdata_next = {27'h0, linear_reg, type_reg};
         end else if (reg_addr == `ELCI_OFF_LINES) begin
            rdata_next = {16'h0, lines_reg};
         end else if (reg_addr == `ELCI_OFF_POLES1) begin
            rdata_next = {24'h0, poles1_reg};
         end else if (reg_addr == `ELCI_OFF_POLES2) begin
            rdata_next = {24'h0, poles2_reg};
         end else if (reg_addr == `ELCI_OFF_STATUS) begin
            rdata_next = {29'h0, state_reg != elci_pkg::st_idle, comm_reg, done_reg};
         end else if (reg_addr == `ELCI_OFF_EFFECTIVE) begin
            rdata_next = {16'h0, eff_reg};
         end else if (reg_addr == `ELCI_OFF_IRQ_STAT) begin
            rdata_next = {29'h0, irq_stat_reg};
         end else if (reg_addr == `ELCI_OFF_IRQ_MASK) begin
            rdata_next = {29'h0, irq_mask_reg};
         end
      end
      // A new event wins over the clearing read in the same cycle
      irq_stat_next = irq_stat_reg;
      if (reg_rd && reg_addr == `ELCI_OFF_IRQ_STAT) begin
         irq_stat_next = 3'h0;
      end
      irq_stat_next = irq_stat_next | irq_event;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_reg <= `ELCI_CTRL_RST;
         type_reg <= elci_pkg::quadrature_incremental;
         linear_reg <= 1'b0;
         lines_reg <= `ELCI_LINES_RST;
         poles1_reg <= `ELCI_POLES_RST;
         poles2_reg <= `ELCI_POLES_RST;
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         rdata_reg <= 32'h0000_0000;
         eff_reg <= 16'h0000;
      end else begin
         ctrl_reg <= ctrl_next;
         type_reg <= type_next;
         linear_reg <= linear_next;
         lines_reg <= lines_next;
         poles1_reg <= poles1_next;
         poles2_reg <= poles2_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         rdata_reg <= rdata_next;
         eff_reg <= eff_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------
   // Initialisation sequencer
   // ----------------------------------------
   logic [7:0] settle_reg, settle_next;
   logic reinit_reg, reinit_next;
   logic autocfg_reg, autocfg_next;
   logic drv_reg, drv_next;
   logic [15:0] ang0_reg, ang0_next;
   logic [15:0] ang_diff, ang_trav;
   logic trig, serial_type, comm_type;

   always_comb begin
      serial_type = (type_reg >= elci_pkg::sine_cosine_serial_type_a);
      comm_type = (type_reg >= elci_pkg::quadrature_with_commutation)
         && (type_reg <= elci_pkg::fwd_rev_with_commutation);
      trig = reinit_wr
         || (trip_reset && restart_trip(trip_code))
         || (cfg_change && ctrl_reg[`ELCI_CTRL_GEN_NEW]);
      state_next = state_reg;
      settle_next = settle_reg;
      done_next = done_reg;
      case (state_reg)
         elci_pkg::st_powerup: begin
            state_next = elci_pkg::st_start;
         end
         elci_pkg::st_start: begin
            state_next = elci_pkg::st_wait;
            settle_next = SETTLE_CYC;
         end
         elci_pkg::st_wait: begin
            // Settle lets ready lines drop before they are trusted again
            if (settle_reg != 8'h00) begin
               settle_next = settle_reg - 8'h01;
            end else if (all_ready) begin
               state_next = elci_pkg::st_idle;
               done_next = 1'b1;
            end
         end
         default: begin
         end
      endcase
      if (trig && state_reg != elci_pkg::st_powerup) begin
         state_next = elci_pkg::st_start;
         done_next = 1'b0;
      end
      if (state_next == elci_pkg::st_start) begin
         done_next = 1'b0;
      end
      reinit_next = (state_next == elci_pkg::st_start) && serial_type;
      autocfg_next = reinit_next && ctrl_reg[`ELCI_CTRL_AUTOCFG];
      drv_next = ctrl_reg[`ELCI_CTRL_DRV_EN] && done_next;
      ang_diff = elec_angle - ang0_reg;
      ang_trav = ang_diff[15] ? 16'(16'h0000 - ang_diff) : ang_diff;
      ang0_next = ang0_reg;
      comm_next = comm_reg;
      if (motor_restart && done_reg && comm_type) begin
         comm_next = 1'b1;
         ang0_next = elec_angle;
      end else if (comm_reg && (ang_trav >= `ELCI_ANG_120 || !done_reg)) begin
         comm_next = 1'b0;
      end
      irq_event[`ELCI_IRQ_DONE] = done_next && !done_reg;
      irq_event[`ELCI_IRQ_START] = (state_next == elci_pkg::st_start);
      irq_event[`ELCI_IRQ_REFUSED] = ctrl_reg[`ELCI_CTRL_DRV_EN] && !done_reg;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= elci_pkg::st_powerup;
         settle_reg <= 8'h00;
         done_reg <= 1'b0;
         reinit_reg <= 1'b0;
         autocfg_reg <= 1'b0;
         drv_reg <= 1'b0;
         comm_reg <= 1'b0;
         ang0_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         settle_reg <= settle_next;
         done_reg <= done_next;
         reinit_reg <= reinit_next;
         autocfg_reg <= autocfg_next;
         drv_reg <= drv_next;
         comm_reg <= comm_next;
         ang0_reg <= ang0_next;
      end
   end

   assign enc_serial_reinit = reinit_reg;
   assign enc_autocfg_run = autocfg_reg;
   assign drive_enable = drv_reg;
   assign commutation_active = comm_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_start;
      state_reg == elci_pkg::st_start && !done_reg;
   endsequence

   sequence s_refill;
      ##1 state_reg == elci_pkg::st_wait ##[1:300] state_reg == elci_pkg::st_idle;
   endsequence

   lines_cap_a: assert property (lines_reg <= `ELCI_LINES_MAX)
      else $error("line setting above limit");
   new_rot_a: assert property (ctrl_reg[0] && type_reg >= elci_pkg::sine_cosine_serial_type_a
      && !linear_reg && lines_reg >= `ELCI_CAP_SC |=> eff_reg == `ELCI_CAP_SC)
      else $error("rotary serial cap wrong");
   new_plain_a: assert property (rst_n && ctrl_reg[0] && (!serial_type || linear_reg)
      |=> eff_reg == $past(lines_reg))
      else $error("newer mapping altered setting");
   old_plain_a: assert property (!ctrl_reg[0] && type_reg <= elci_pkg::fwd_rev_incremental
      && lines_reg > `ELCI_PLAIN_LIM_OLD |=> eff_reg == {$past(lines_reg[15:2]), 2'b00})
      else $error("older plain rounding wrong");
   old_comm_a: assert property (!ctrl_reg[0] && comm_type && lines_reg <= `ELCI_MIN_OLD
      |=> eff_reg == `ELCI_MIN_OLD)
      else $error("older servo floor wrong");
   old_sc_a: assert property (!ctrl_reg[0] && type_reg >= elci_pkg::sine_cosine_plain
      && lines_reg > `ELCI_MIN_OLD |=> eff_reg <= $past(lines_reg) && $onehot(eff_reg))
      else $error("older sine-cosine mapping wrong");
   done_gate_a: assert property (drive_enable |-> done_reg)
      else $error("drive enabled before init done");
   reinit_req_a: assert property (reinit_wr && state_reg != elci_pkg::st_powerup
      |=> s_start)
      else $error("reinit request ignored");
   trip_start_a: assert property (trip_reset && restart_trip(trip_code)
      && state_reg != elci_pkg::st_powerup |=> s_start)
      else $error("trip reset did not restart init");
   old_gen_a: assert property (cfg_change && !ctrl_reg[0] && !reinit_wr && !trip_reset
      && state_reg == elci_pkg::st_idle |=> done_reg)
      else $error("older generation restarted on change");
   done_set_a: assert property (state_reg == elci_pkg::st_wait && settle_reg == 8'h00
      && all_ready && !trig |=> done_reg ##0 state_reg == elci_pkg::st_idle)
      else $error("done not set when ready");
   serial_pulse_a: assert property (s_start |-> enc_serial_reinit == serial_type
      && enc_autocfg_run == (serial_type && ctrl_reg[1]) ##1 !enc_serial_reinit)
      else $error("serial reinit pulse wrong");
   commut_a: assert property (motor_restart && done_reg && comm_type
      |=> commutation_active)
      else $error("commutation window not opened");

endmodule

/* test/elci_enc_model.sv */
// Behavioural encoders: main and option encoders report ready after a delay.
// Assumes restart pulses and the design's serial re-init pulse share core_clk.
`timescale 1ns/1ns
module elci_enc_model #(
   parameter int N_OPT = 2
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic enc_serial_reinit,
   input wire logic [7:0] main_dly,
   input wire logic [7:0] opt_dly,
   output logic main_ready,
   output logic [N_OPT-1:0] opt_ready
);
   logic [8:0] cnt_reg;
   // Power-up and every restart drop ready until the encoder has set itself up
   always @(posedge core_clk) begin
      if (!rst_n || restart || enc_serial_reinit) begin
         cnt_reg <= 9'h000;
      end else if (cnt_reg != 9'h1ff) begin
         cnt_reg <= cnt_reg + 9'h001;
      end
   end
   assign main_ready = cnt_reg >= {1'b0, main_dly};
   // All option encoders share one delay; enough to show the slowest one gates done
   assign opt_ready = {N_OPT{cnt_reg >= {1'b0, opt_dly}}};
endmodule

/* test/testbench.sv */
// Self-checking bench for the line-count and initialisation block.
// Assumes the design constants header and the behavioural encoder model.
`include "elci_consts.svh"
`timescale 1ns/1ns
module testbench;
   logic core_clk, rst_n, reg_wr, reg_rd, trip_reset, motor_restart, enc_restart;
   logic main_ready, enc_serial_reinit, enc_autocfg_run, drive_enable, commutation_active, irq;
   logic [7:0] reg_addr, main_dly, opt_dly;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [1:0] opt_ready;
   logic [4:0] trip_code;
   logic [15:0] elec_angle;
   int bad_count, num_checks, n_reinit, n_autocfg, r0, a0, i;
   logic [4:0] codes [8] = '{5'h01, 5'h08, 5'h0b, 5'h11, 5'h1f, 5'h09, 5'h12, 5'h00};
   logic [7:0] hits = 8'h1f;

   elci_top DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .enc_main_ready(main_ready), .opt_enc_ready(opt_ready), .trip_reset(trip_reset),
      .trip_code(trip_code), .motor_restart(motor_restart), .elec_angle(elec_angle),
      .enc_serial_reinit(enc_serial_reinit), .enc_autocfg_run(enc_autocfg_run),
      .drive_enable(drive_enable), .commutation_active(commutation_active), .irq(irq));
   elci_enc_model encm (.core_clk(core_clk), .rst_n(rst_n), .restart(enc_restart),
      .enc_serial_reinit(enc_serial_reinit), .main_dly(main_dly), .opt_dly(opt_dly),
      .main_ready(main_ready), .opt_ready(opt_ready));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (enc_serial_reinit === 1'b1) n_reinit++;
      if (enc_autocfg_run === 1'b1) n_autocfg++;
   end

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   // Every task that drives a strobe starts on a fresh edge, so a strobe is never set and cleared in one step
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a, rv);
      chk(rv, exp);
   endtask
   task report_and_stop;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task wait_done;
      int k;
      for (k = 0; k < 400; k++) begin
         rd(`ELCI_OFF_STATUS, rv);
         if (rv[0] === 1'b1) break;
      end
      if (k == 400) begin
         bad_count++;
         report_and_stop;
      end
   endtask
   // Reads and clears the sticky bits, then checks only the start-of-init bit
   task probe(input logic exp);
      rd(`ELCI_OFF_IRQ_STAT, rv);
      chk({31'h0, rv[`ELCI_IRQ_START]}, {31'h0, exp});
   endtask
   task pulse_trip(input logic [4:0] c);
      @(posedge core_clk);
      trip_reset <= 1'b1;
      trip_code <= c;
      @(posedge core_clk);
      trip_reset <= 1'b0;
   endtask
   task map_case(input logic g, input logic [3:0] t, input logic l, input logic [15:0] s,
      input logic [15:0] e);
      wr(`ELCI_OFF_CTRL, {31'h0, g});
      wr(`ELCI_OFF_ENC_CFG, {27'h0, l, t});
      wr(`ELCI_OFF_LINES, {16'h0, s});
      rchk(`ELCI_OFF_EFFECTIVE, {16'h0, e});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {reg_wr, reg_rd, trip_reset, motor_restart, enc_restart} = 5'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      trip_code = 5'h00;
      elec_angle = 16'h0000;
      main_dly = 8'h10;
      opt_dly = 8'h20;
      rst_n = 1'b0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      rchk(`ELCI_OFF_CTRL, 32'h1);
      rchk(`ELCI_OFF_LINES, 32'h400);
      rchk(`ELCI_OFF_POLES1, 32'h4);
      rchk(`ELCI_OFF_POLES2, 32'h4);
      rchk(`ELCI_OFF_STATUS, 32'h4);
      rchk(`ELCI_OFF_IRQ_STAT, 32'h2);
      rchk(8'h30, 32'h0);
      wr(`ELCI_OFF_CTRL, 32'h5);
      @(negedge core_clk) chk({31'h0, drive_enable}, 32'h0);
      rd(`ELCI_OFF_IRQ_STAT, rv);
      chk({31'h0, rv[`ELCI_IRQ_REFUSED]}, 32'h1);
      wait_done;
      @(negedge core_clk) chk({31'h0, drive_enable}, 32'h1);
      // A slow option encoder must hold the done flag off
      opt_dly = 8'hc8;
      @(posedge core_clk) enc_restart <= 1'b1;
      wr(`ELCI_OFF_REINIT, 32'h1);
      enc_restart <= 1'b0;
      repeat (120) @(posedge core_clk);
      rd(`ELCI_OFF_STATUS, rv);
      chk({31'h0, rv[0]}, 32'h0);
      chk({31'h0, drive_enable}, 32'h0);
      wait_done;
      opt_dly = 8'h20;
      probe(1'b1);
      for (i = 0; i < 8; i++) begin
         pulse_trip(codes[i]);
         probe(hits[i]);
      end
      wr(`ELCI_OFF_POLES1, 32'h6);
      probe(1'b1);
      wr(`ELCI_OFF_POLES2, 32'h6);
      probe(1'b1);
      wr(`ELCI_OFF_CTRL, 32'h4);
      // Let the sequencer reach idle so the ignored change is seen from idle
      wait_done;
      wr(`ELCI_OFF_LINES, 32'h3e9);
      probe(1'b0);
      wr(`ELCI_OFF_POLES1, 32'h8);
      probe(1'b0);
      map_case(1'b1, 4'h0, 1'b0, 16'h0000, 16'h0000);
      map_case(1'b1, 4'h3, 1'b0, 16'hea60, 16'hc350);
      map_case(1'b1, 4'h6, 1'b0, 16'h03e7, 16'h03e7);
      map_case(1'b1, 4'h7, 1'b0, 16'h0000, 16'h0001);
      map_case(1'b1, 4'h8, 1'b0, 16'h03e8, 16'h0200);
      map_case(1'b1, 4'h9, 1'b0, 16'h9c40, 16'h8000);
      map_case(1'b1, 4'h7, 1'b1, 16'h03e8, 16'h03e8);
      map_case(1'b0, 4'h0, 1'b0, 16'h0001, 16'h0002);
      map_case(1'b0, 4'h2, 1'b0, 16'h4000, 16'h4000);
      map_case(1'b0, 4'h1, 1'b0, 16'h4e23, 16'h4e20);
      map_case(1'b0, 4'h4, 1'b0, 16'h0003, 16'h0002);
      map_case(1'b0, 4'h5, 1'b0, 16'h3fff, 16'h2000);
      map_case(1'b0, 4'h3, 1'b0, 16'h4e20, 16'h4000);
      map_case(1'b0, 4'h6, 1'b0, 16'h0002, 16'h0002);
      map_case(1'b0, 4'h9, 1'b0, 16'h7fff, 16'h4000);
      map_case(1'b0, 4'h8, 1'b1, 16'h9c40, 16'h8000);
      wr(`ELCI_OFF_CTRL, 32'h3);
      wr(`ELCI_OFF_ENC_CFG, 32'h7);
      r0 = n_reinit;
      a0 = n_autocfg;
      wr(`ELCI_OFF_REINIT, 32'h1);
      repeat (3) @(posedge core_clk);
      chk(32'(n_reinit - r0), 32'h1);
      chk(32'(n_autocfg - a0), 32'h1);
      wr(`ELCI_OFF_ENC_CFG, 32'h3);
      wr(`ELCI_OFF_IRQ_MASK, 32'h1);
      wait_done;
      @(negedge core_clk) chk({31'h0, irq}, 32'h1);
      wr(`ELCI_OFF_IRQ_MASK, 32'h0);
      @(negedge core_clk) chk({31'h0, irq}, 32'h0);
      wr(`ELCI_OFF_IRQ_MASK, 32'h1);
      rd(`ELCI_OFF_IRQ_STAT, rv);
      @(negedge core_clk) chk({31'h0, irq}, 32'h0);
      @(posedge core_clk) elec_angle <= 16'h1000;
      @(posedge core_clk) motor_restart <= 1'b1;
      @(posedge core_clk) motor_restart <= 1'b0;
      elec_angle <= 16'h6554;
      repeat (2) @(negedge core_clk);
      chk({31'h0, commutation_active}, 32'h1);
      @(posedge core_clk) elec_angle <= 16'h6555;
      repeat (3) @(negedge core_clk);
      chk({31'h0, commutation_active}, 32'h0);
      report_and_stop;
   end
endmodule
